// file: cbci_bus_cycle.sv
// cbci_bus_cycle: machine-cycle sequencer, multiplexed memory bus and AXI4-Lite status port
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
module cbci_bus_cycle
	import cbci_pkg::*;
(
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// register bus
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// mode and request pins
	input  wire logic        clear_n,
	input  wire logic        wait_n,
	input  wire logic        interrupt_n,
	input  wire logic        dma_input_request_n,
	input  wire logic        dma_output_request_n,
	input  wire logic [3:0]  external_status_flags_n,
	// memory and I/O bus
	output logic             first_timing_pulse,
	output logic             second_timing_pulse,
	output logic [7:0]       multiplexed_address_lines,
	output logic             memory_read_level_n,
	output logic             memory_write_strobe_n,
	output logic [1:0]       state_code_lines,
	output logic [2:0]       io_command_lines,
	output logic             output_flag_bit,
	input  wire logic [7:0]  data_in,
	output logic [7:0]       data_out,
	output logic             data_oe
);
	// =====================================================
	// pin synchronisers
	localparam int unsigned SYNC_W = 9;
	// clear reads low until the pins are seen, so the core waits in reset mode after release
	localparam logic [SYNC_W-1:0] SYNC_RST = {1'b0, {(SYNC_W-1){1'b1}}};
	logic [SYNC_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
	logic              clr_s, wt_s, int_n_s, di_n_s, do_n_s;
	logic [3:0]        ef_n_s;
	logic [7:0]        din_s;
	assign {clr_s, wt_s, int_n_s, di_n_s, do_n_s, ef_n_s} = filt_reg;
	// data bus answers our own strobes on this clock; a synchroniser would land the byte after the sampling edge
	assign din_s = data_in;

	// a bit moves only once stages two and three agree
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s1_reg   <= SYNC_RST;
			s2_reg   <= SYNC_RST;
			s3_reg   <= SYNC_RST;
			filt_reg <= SYNC_RST;
		end
		else
		begin
			s1_reg   <= {clear_n, wait_n, interrupt_n, dma_input_request_n, dma_output_request_n,
				external_status_flags_n};
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			filt_reg <= (s3_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
		end
	end

	// =====================================================
	// decode helpers
	function automatic logic [1:0] sc_of(cbci_state_t st);
		case (st)
			ST_FETCH: sc_of = SC_FETCH;
			ST_EXEC:  sc_of = SC_EXEC;
			ST_DMA:   sc_of = SC_DMA;
			default:  sc_of = SC_INT;
		endcase
	endfunction

	function automatic logic [3:0] addr_sel(cbci_state_t st, logic [7:0] op, logic [3:0] p, logic [3:0] x);
		addr_sel = p;
		if (st == ST_DMA)
			addr_sel = DMA_REG;
		else if (st == ST_EXEC)
		begin
			if (op[7:4] == NIB_LDN || op[7:4] == NIB_LDA || op[7:4] == NIB_STR)
				addr_sel = op[3:0];
			else if (op[7:4] == NIB_IO || op[7:4] == NIB_MISC)
				addr_sel = x;
		end
	endfunction

	// {enable, decrement, register index} applied at cycle end
	function automatic logic [5:0] step_of(cbci_state_t st, logic [7:0] op, logic [3:0] p, logic [3:0] x);
		step_of = '0;
		case (st)
			ST_FETCH: step_of = {STEP_INC, p};
			ST_DMA:   step_of = {STEP_INC, DMA_REG};
			ST_EXEC:
			begin
				if (op[7:4] == NIB_LDA)
					step_of = {STEP_INC, op[3:0]};
				else if (op[7:4] == NIB_LONG)
					step_of = {STEP_INC, p};
				else if (op == OP_STXD)
					step_of = {STEP_DEC, x};
				else if ((op[7:4] == NIB_IO && !op[3]) || op == OP_RET || op == OP_DIS || op == OP_LDXA)
					step_of = {STEP_INC, x};
			end
			default: step_of = '0;
		endcase
	endfunction

	// =====================================================
	// sequencer
	cbci_mode_t  mode;
	cbci_state_t st_reg, st_next, pick;
	logic [2:0]  phase_reg;
	logic [7:0]  op_reg;
	logic        exec2_reg, dma_in_reg, pend_int, pend_di, pend_do;
	logic        advance, cyc_end, long_first, io_op, wr_cyc, rd_cyc, cpu_drv;
	logic [3:0]  p_reg, x_reg;
	logic        ie_reg;

	assign mode       = cbci_mode_t'({clr_s, wt_s});
	assign advance    = (mode == MODE_RUN) || (mode == MODE_LOAD);
	assign cyc_end    = advance && phase_reg == PH_LAST;
	assign long_first = st_reg == ST_EXEC && op_reg[7:4] == NIB_LONG && !exec2_reg;
	assign io_op      = op_reg[7:4] == NIB_IO && op_reg[2:0] != 3'h0;
	assign cpu_drv    = st_reg == ST_EXEC && (op_reg[7:4] == NIB_STR || op_reg == OP_STXD || op_reg == OP_SAV);
	assign wr_cyc     = (st_reg == ST_DMA && dma_in_reg) || cpu_drv || (st_reg == ST_EXEC && io_op && op_reg[3]);
	assign rd_cyc     = !wr_cyc && st_reg != ST_INT;

	always_comb
	begin
		pick = ST_FETCH;
		if (pend_di || pend_do)
			pick = ST_DMA;
		else if (pend_int && ie_reg)
			pick = ST_INT;
		else if (mode == MODE_LOAD || (st_reg == ST_EXEC && op_reg == OP_IDLE))
			pick = ST_EXEC;
		case (st_reg)
			ST_FETCH: st_next = (mode == MODE_LOAD) ? pick : ST_EXEC;
			ST_EXEC:  st_next = long_first ? ST_EXEC : pick;
			ST_DMA:   st_next = pick;
			ST_INT:   st_next = ST_FETCH;
			default:  st_next = ST_FETCH;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || mode == MODE_RESET)
		begin
			phase_reg  <= 3'h0;
			st_reg     <= ST_FETCH;
			op_reg     <= OP_IDLE;
			exec2_reg  <= 1'b0;
			dma_in_reg <= 1'b0;
			pend_int   <= 1'b0;
			pend_di    <= 1'b0;
			pend_do    <= 1'b0;
		end
		else if (advance)
		begin
			phase_reg <= 3'(phase_reg + 3'h1);
			if (phase_reg == PH_TPB)
			begin
				pend_int <= !int_n_s;
				pend_di  <= !di_n_s;
				pend_do  <= !do_n_s;
			end
			if (mode == MODE_LOAD)
				op_reg <= OP_IDLE;
			else if (phase_reg == PH_TPB && st_reg == ST_FETCH)
				op_reg <= din_s;
			if (cyc_end)
			begin
				st_reg    <= st_next;
				exec2_reg <= long_first;
				if (st_next == ST_DMA)
					dma_in_reg <= pend_di;
			end
		end
	end

	// =====================================================
	// register array and processor state
	logic [15:0] r_reg [16];
	logic [15:0] cur_addr, r0;
	logic [7:0]  addr_hi, t_reg, ld_reg, acc_reg;
	logic [5:0]  step;
	logic [3:0]  flags_reg;
	logic        op_n3;
	logic        ctrl_wr;
	logic [31:0] wdata_q;
	assign cur_addr = r_reg[addr_sel(st_reg, op_reg, p_reg, x_reg)];
	assign addr_hi  = cur_addr[15:8];
	assign r0       = r_reg[DMA_REG];
	assign step     = step_of(st_reg, op_reg, p_reg, x_reg);
	assign op_n3    = op_reg[3];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 16; i++)
				r_reg[i] <= '0;
		end
		else if (mode == MODE_RESET)
			r_reg[DMA_REG] <= '0;
		else if (cyc_end && step[5])
			r_reg[step[3:0]] <= step[4] ? r_reg[step[3:0]] - 16'h0001 : r_reg[step[3:0]] + 16'h0001;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || mode == MODE_RESET)
		begin
			p_reg           <= 4'h0;
			x_reg           <= 4'h0;
			t_reg           <= 8'h00;
			ie_reg          <= 1'b1;
			output_flag_bit <= 1'b0;
			flags_reg       <= 4'h0;
			ld_reg          <= 8'h00;
		end
		else
		begin
			if (ctrl_wr)
				ie_reg <= wdata_q[CTRL_IE_BIT];
			if (advance && st_reg == ST_EXEC && phase_reg == PH_FLAG)
				flags_reg <= ~ef_n_s;
			if (advance && st_reg == ST_EXEC && phase_reg == PH_Q)
			begin
				if (op_reg == OP_SEQ)
					output_flag_bit <= 1'b1;
				else if (op_reg == OP_REQ)
					output_flag_bit <= 1'b0;
			end
			if (advance && phase_reg == PH_TPB && st_reg == ST_EXEC && rd_cyc)
				ld_reg <= din_s;
			if (cyc_end && st_reg == ST_INT)
			begin
				t_reg  <= {x_reg, p_reg};
				x_reg  <= INT_X;
				p_reg  <= INT_P;
				ie_reg <= 1'b0;
			end
			else if (cyc_end && st_reg == ST_EXEC)
			begin
				if (op_reg[7:4] == NIB_SEP)
					p_reg <= op_reg[3:0];
				else if (op_reg[7:4] == NIB_SEX)
					x_reg <= op_reg[3:0];
				else if (op_reg == OP_RET || op_reg == OP_DIS)
				begin
					{x_reg, p_reg} <= din_s;
					ie_reg         <= !op_reg[0];
				end
			end
		end
	end

	// =====================================================
	// bus pins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			first_timing_pulse        <= 1'b0;
			second_timing_pulse       <= 1'b0;
			multiplexed_address_lines <= 8'h00;
			memory_read_level_n       <= 1'b1;
			memory_write_strobe_n     <= 1'b1;
			state_code_lines          <= SC_FETCH;
			io_command_lines          <= 3'h0;
			data_oe                   <= 1'b0;
			data_out                  <= 8'h00;
		end
		else
		begin
			first_timing_pulse  <= phase_reg == PH_TPA && !(mode == MODE_LOAD && st_reg == ST_EXEC);
			second_timing_pulse <= phase_reg == PH_TPB;
			// high byte stays through the falling first pulse so memory can latch it
			multiplexed_address_lines <= (phase_reg < PH_LOW) ? addr_hi : cur_addr[7:0];
			memory_read_level_n   <= !rd_cyc;
			memory_write_strobe_n <= !(wr_cyc && phase_reg >= PH_WR_ON && phase_reg < PH_WR_OFF);
			state_code_lines      <= sc_of(st_reg);
			io_command_lines      <= (st_reg == ST_EXEC && io_op) ? op_reg[2:0] : 3'h0;
			data_oe               <= cpu_drv;
			data_out              <= (op_reg == OP_SAV) ? t_reg : acc_reg;
		end
	end

	// =====================================================
	// AXI4-Lite slave
	logic [7:0] aw_q;
	logic       aw_got, w_got, wr_fire;
	logic [3:0] wstrb_q;
	assign wr_fire = aw_got && w_got && !bvalid;
	assign ctrl_wr = wr_fire && aw_q == ADDR_CTRL && wstrb_q[0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b1;
			wready  <= 1'b1;
			aw_got  <= 1'b0;
			w_got   <= 1'b0;
			aw_q    <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OK;
			acc_reg <= 8'h00;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_q    <= awaddr;
				aw_got  <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready)
			begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
				w_got   <= 1'b1;
				wready  <= 1'b0;
			end
			if (wr_fire)
			begin
				aw_got <= 1'b0;
				w_got  <= 1'b0;
				bvalid <= 1'b1;
				bresp  <= (aw_q == ADDR_CTRL || aw_q == ADDR_STAT || aw_q == ADDR_LOAD || aw_q == ADDR_R0)
					? RESP_OK : RESP_ERR;
				if (aw_q == ADDR_CTRL && wstrb_q[1])
					acc_reg <= wdata_q[CTRL_ACC_LSB +: 8];
			end
			if (bvalid && bready)
			begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// read data is built from the live state at the edge the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= RESP_OK;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= RESP_OK;
			rdata   <= 32'h0;
			case (araddr)
				ADDR_CTRL:
				begin
					rdata[CTRL_IE_BIT]       <= ie_reg;
					rdata[CTRL_ACC_LSB +: 8] <= acc_reg;
				end
				ADDR_STAT:
				begin
					rdata[1:0]                <= sc_of(st_reg);
					rdata[STAT_Q_BIT]         <= output_flag_bit;
					rdata[STAT_IE_BIT]        <= ie_reg;
					rdata[STAT_FLAG_LSB +: 4] <= flags_reg;
					rdata[STAT_P_LSB +: 4]    <= p_reg;
					rdata[STAT_X_LSB +: 4]    <= x_reg;
					rdata[STAT_T_LSB +: 8]    <= t_reg;
				end
				ADDR_LOAD:
				begin
					rdata[7:0]              <= ld_reg;
					rdata[LOAD_OP_LSB +: 8] <= op_reg;
				end
				ADDR_R0: rdata[15:0] <= r0;
				default: rresp <= RESP_ERR;
			endcase
		end
		else if (rvalid && rready)
		begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// =====================================================
	// assertions
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_PHASE_EIGHT: assert property ((advance && phase_reg == 3'h0) ##1 advance [*7] |=> phase_reg == 3'h0)
		else $error("machine cycle is not eight clocks");
	AST_TPB_FOLLOWS: assert property ((mode == MODE_RUN && phase_reg == PH_TPA) ##1 (mode == MODE_RUN) [*5]
		|=> second_timing_pulse && !first_timing_pulse)
		else $error("second pulse missing after first");
	AST_LOAD_NO_TPA: assert property ((mode == MODE_LOAD && $past(mode) == MODE_LOAD && $past(st_reg) == ST_EXEC)
		|-> !first_timing_pulse)
		else $error("first pulse seen in load idle");
	AST_HIGH_AT_TPA: assert property (first_timing_pulse |-> multiplexed_address_lines == $past(addr_hi))
		else $error("high address byte not shown at first pulse");
	AST_WR_PULSE: assert property (disable iff (!aresetn || mode != MODE_RUN)
		$fell(memory_write_strobe_n) |-> memory_read_level_n ##1 !memory_write_strobe_n ##1 memory_write_strobe_n)
		else $error("write strobe shape wrong");
	AST_RD_STEADY: assert property (($changed(memory_read_level_n) && $past(mode) == MODE_RUN) |-> phase_reg == PH_TPA)
		else $error("read level moved inside a cycle");
	AST_IO_DIR: assert property (io_command_lines != 3'h0 |-> memory_read_level_n == $past(op_n3)
		&& state_code_lines == SC_EXEC)
		else $error("I/O lines or direction wrong");
	AST_FLAG_SAMPLE: assert property ((advance && st_reg == ST_EXEC && phase_reg == PH_FLAG)
		|=> flags_reg == ~$past(ef_n_s))
		else $error("status flags not sampled");
	AST_INT_ACTION: assert property ((cyc_end && st_reg == ST_INT) |=> p_reg == INT_P && x_reg == INT_X
		&& !ie_reg && t_reg == {$past(x_reg), $past(p_reg)})
		else $error("interrupt cycle did not save and set designators");
	AST_DMA_INC: assert property ((cyc_end && st_reg == ST_DMA) |=> r0 == $past(r0) + 16'h0001)
		else $error("register zero not incremented");
	AST_PRIORITY: assert property ((cyc_end && st_reg == ST_EXEC && !long_first && pend_int && (pend_di || pend_do))
		|=> st_reg == ST_DMA && dma_in_reg == $past(pend_di))
		else $error("request priority wrong");
	AST_SC_AT_TPA: assert property (first_timing_pulse |-> state_code_lines == sc_of(st_reg))
		else $error("state code not valid at first pulse");
	AST_Q_WINDOW: assert property (($changed(output_flag_bit) && $past(mode) == MODE_RUN) |-> $past(phase_reg) == PH_Q)
		else $error("output flag moved outside its window");

	COV_DMA: cover property (cyc_end && st_reg == ST_DMA);
	COV_INT: cover property (cyc_end && st_reg == ST_INT);
	COV_LONG: cover property (cyc_end && long_first);
	COV_WRITE: cover property ($fell(memory_write_strobe_n));
endmodule

// file: cbci_memory_model.sv
// cbci_memory_model: behavioural memory and I/O device on the multiplexed bus
module cbci_memory_model
(
	// clock
	input  wire logic       aclk,
	// device bus
	input  wire logic       first_timing_pulse,
	input  wire logic [7:0] multiplexed_address_lines,
	input  wire logic       memory_read_level_n,
	input  wire logic       memory_write_strobe_n,
	input  wire logic [1:0] state_code_lines,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	// resolved data bus
	output logic      [7:0] data_in
);
	timeunit 1ns;
	timeprecision 100ps;
	parameter logic [7:0] DMA_BYTE = 8'h3C;
	logic [7:0] mem [0:255];
	logic [7:0] addr_hi;
	logic [7:0] last_bus;
	logic       tpa_d;
	logic [7:0] rd_byte;
	// =====================================================
	// program: flag on, data pointer 3, output, long skip, store over the idle slot
	initial
	begin
		foreach (mem[i]) mem[i] = 8'h00;
		mem[0] = 8'h7B;
		mem[1] = 8'hE3;
		mem[2] = 8'h61;
		mem[3] = 8'hC0;
		mem[6] = 8'h50;
		mem[7] = 8'hFF;
		addr_hi = 8'h00;
		last_bus = 8'h00;
		tpa_d = 1'b0;
	end
	// an unknown pointer reads as idle rather than spreading unknowns
	assign rd_byte = $isunknown(multiplexed_address_lines) ? 8'h00 : mem[multiplexed_address_lines];
	// =====================================================
	// bus resolution; a released bus shows the inverse of its last value
	always_comb
	begin
		if (data_oe)
			data_in = data_out;
		else if (!memory_read_level_n)
			data_in = rd_byte;
		else if (state_code_lines == 2'h2)
			data_in = DMA_BYTE;
		else
			data_in = ~last_bus;
	end
	always @(posedge aclk)
	begin
		tpa_d <= first_timing_pulse;
		last_bus <= data_in;
		if (tpa_d && !first_timing_pulse)
			addr_hi <= multiplexed_address_lines;
		if (!memory_write_strobe_n)
			mem[multiplexed_address_lines] <= data_in;
	end
endmodule

// file: cbci_pkg.sv
// cbci_pkg: constants and types shared by the bus-cycle interface
package cbci_pkg;
	// =====================================================
	// machine cycle phases (eight clocks per cycle)
	localparam int unsigned CYCLE_CLOCKS = 8;
	localparam logic [2:0] PH_FLAG   = 3'h0;
	localparam logic [2:0] PH_TPA    = 3'h1;
	localparam logic [2:0] PH_LOW    = 3'h3;
	localparam logic [2:0] PH_Q      = 3'h3;
	localparam logic [2:0] PH_WR_ON  = 3'h4;
	localparam logic [2:0] PH_WR_OFF = 3'h6;
	localparam logic [2:0] PH_TPB    = 3'h6;
	localparam logic [2:0] PH_LAST   = 3'h7;
	// =====================================================
	// state codes and opcodes
	localparam logic [1:0] SC_FETCH = 2'h0;
	localparam logic [1:0] SC_EXEC  = 2'h1;
	localparam logic [1:0] SC_DMA   = 2'h2;
	localparam logic [1:0] SC_INT   = 2'h3;
	localparam logic [7:0] OP_IDLE  = 8'h00;
	localparam logic [7:0] OP_RET   = 8'h70;
	localparam logic [7:0] OP_DIS   = 8'h71;
	localparam logic [7:0] OP_LDXA  = 8'h72;
	localparam logic [7:0] OP_STXD  = 8'h73;
	localparam logic [7:0] OP_SAV   = 8'h78;
	localparam logic [7:0] OP_REQ   = 8'h7A;
	localparam logic [7:0] OP_SEQ   = 8'h7B;
	localparam logic [3:0] NIB_LDN  = 4'h0;
	localparam logic [3:0] NIB_LDA  = 4'h4;
	localparam logic [3:0] NIB_STR  = 4'h5;
	localparam logic [3:0] NIB_IO   = 4'h6;
	localparam logic [3:0] NIB_MISC = 4'h7;
	localparam logic [3:0] NIB_LONG = 4'hC;
	localparam logic [3:0] NIB_SEP  = 4'hD;
	localparam logic [3:0] NIB_SEX  = 4'hE;
	localparam logic [3:0] INT_X    = 4'h2;
	localparam logic [3:0] INT_P    = 4'h1;
	localparam logic [3:0] DMA_REG  = 4'h0;
	localparam logic [1:0] STEP_INC = 2'h2;
	localparam logic [1:0] STEP_DEC = 2'h3;
	// =====================================================
	// register map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_LOAD = 8'h08;
	localparam logic [7:0] ADDR_R0   = 8'h0C;
	localparam logic [1:0] RESP_OK   = 2'h0;
	localparam logic [1:0] RESP_ERR  = 2'h2;
	localparam int unsigned CTRL_IE_BIT = 0;
	localparam int unsigned CTRL_ACC_LSB = 8;
	localparam int unsigned STAT_Q_BIT = 2;
	localparam int unsigned STAT_IE_BIT = 3;
	localparam int unsigned STAT_FLAG_LSB = 4;
	localparam int unsigned STAT_P_LSB = 8;
	localparam int unsigned STAT_X_LSB = 12;
	localparam int unsigned STAT_T_LSB = 16;
	localparam int unsigned LOAD_OP_LSB = 8;
	// =====================================================
	// types
	typedef enum logic [1:0] {MODE_LOAD, MODE_RESET, MODE_PAUSE, MODE_RUN} cbci_mode_t;
	typedef enum logic [1:0] {ST_FETCH, ST_EXEC, ST_DMA, ST_INT} cbci_state_t;
endpackage

// file: test_cpu_bus_cycle_interface.sv
// test_cpu_bus_cycle_interface: self-checking bench for the bus-cycle block
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; $display("mismatch %s exp %0h seen %0h", n, e, g); end end
module test_cpu_bus_cycle_interface;
	import cbci_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, multiplexed_address_lines, data_in, data_out;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0, external_status_flags_n = 4'h5;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, data_oe;
	logic [1:0] bresp, rresp, state_code_lines;
	logic clear_n = 1'b0, wait_n = 1'b1, interrupt_n = 1'b1;
	logic dma_input_request_n = 1'b1, dma_output_request_n = 1'b1;
	logic first_timing_pulse, second_timing_pulse, memory_read_level_n, memory_write_strobe_n;
	logic [2:0] io_command_lines;
	logic output_flag_bit;
	int errors = 0, compares = 0, cyc = 0, ltpa = 0, ntpa = 0, n0, i;
	logic [1:0] scq [$];
	logic [1:0] r;
	logic [31:0] d;

	cbci_bus_cycle dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.clear_n, .wait_n, .interrupt_n, .dma_input_request_n, .dma_output_request_n, .external_status_flags_n,
		.first_timing_pulse, .second_timing_pulse, .multiplexed_address_lines, .memory_read_level_n,
		.memory_write_strobe_n, .state_code_lines, .io_command_lines, .output_flag_bit, .data_in, .data_out, .data_oe);
	cbci_memory_model mem_model (.aclk, .first_timing_pulse, .multiplexed_address_lines, .memory_read_level_n,
		.memory_write_strobe_n, .state_code_lines, .data_out, .data_oe, .data_in);

	always #4 aclk = ~aclk;
	// =====================================================
	// cycle monitor: pulse spacing and state code at each first pulse
	always @(posedge aclk)
	begin
		if (first_timing_pulse === 1'b1)
		begin
			if (ntpa != 0) `CHK("tpa spacing", 0, (cyc - ltpa) % 8)
			ntpa <= ntpa + 1;
			ltpa <= cyc;
			scq.push_back(state_code_lines);
		end
		if (second_timing_pulse === 1'b1 && ntpa != 0 && cyc - ltpa < 8) `CHK("tpb offset", 5, cyc - ltpa)
		cyc <= cyc + 1;
	end
	// sized well beyond the roughly 300 cycles the sequence needs
	always @(posedge aclk)
	begin
		if (cyc == 20000)
		begin
			errors++;
			close_out();
		end
	end
	// =====================================================
	// register bus master
	task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) begin awvalid <= 1'b0; aw_done = 1'b1; end
			if (wvalid && wready === 1'b1) begin wvalid <= 1'b0; w_done = 1'b1; end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic wait_tpa();
		do @(posedge aclk); while (first_timing_pulse !== 1'b1);
	endtask
	task automatic close_out();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// =====================================================
	// main sequence
	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_write(ADDR_CTRL, 32'h0000_0001, r);
		`CHK("ctrl bresp", RESP_OK, r)
		axi_write(ADDR_STAT, 32'hFFFF_FFFF, r);
		`CHK("ro bresp", RESP_OK, r)
		axi_read(8'h10, d, r);
		`CHK("unmapped rresp", RESP_ERR, r)
		`CHK("unmapped rdata", 32'h0, d)
		$display("test registers done");
		clear_n <= 1'b1;
		for (i = 0; i < 400 && io_command_lines !== 3'h1; i++) @(posedge aclk);
		`CHK("io lines", 3'h1, io_command_lines)
		`CHK("io direction", 1'b0, memory_read_level_n)
		`CHK("io state", SC_EXEC, state_code_lines)
		repeat (100) @(posedge aclk);
		for (i = 0; i < 13; i++) `CHK("state code", ((i < 8) ^ (i % 2 == 0)) ? SC_EXEC : SC_FETCH, scq[i])
		`CHK("flag out", 1'b1, output_flag_bit)
		`CHK("stored byte", 8'h00, mem_model.mem[7])
		axi_read(ADDR_R0, d, r);
		`CHK("r0 after program", 16'h0008, d[15:0])
		axi_read(ADDR_STAT, d, r);
		`CHK("sampled flags", 4'hA, d[STAT_FLAG_LSB +: 4])
		`CHK("flag status", 1'b1, d[STAT_Q_BIT])
		$display("test program done");
		clear_n <= 1'b0;
		wait_n <= 1'b0;
		repeat (8) @(posedge aclk);
		n0 = ntpa;
		repeat (48) @(posedge aclk);
		`CHK("tpa in load idle", n0, ntpa)
		clear_n <= 1'b1;
		wait_n <= 1'b1;
		repeat (24) @(posedge aclk);
		$display("test load done");
		dma_input_request_n <= 1'b0;
		interrupt_n <= 1'b0;
		// drop the request as soon as the dma state shows, ahead of the next request sample
		do @(posedge aclk); while (state_code_lines !== SC_DMA);
		dma_input_request_n <= 1'b1;
		do @(posedge aclk); while (state_code_lines === SC_DMA);
		`CHK("after dma", SC_INT, state_code_lines)
		interrupt_n <= 1'b1;
		repeat (4) @(posedge aclk);
		axi_read(ADDR_R0, d, r);
		`CHK("r0 after dma", 16'h0009, d[15:0])
		`CHK("dma byte", 8'h3C, mem_model.mem[8])
		`CHK("high address", 8'h00, mem_model.addr_hi)
		axi_read(ADDR_STAT, d, r);
		`CHK("int p", INT_P, d[STAT_P_LSB +: 4])
		`CHK("int x", INT_X, d[STAT_X_LSB +: 4])
		`CHK("int ie", 1'b0, d[STAT_IE_BIT])
		`CHK("saved pair", 8'h30, d[STAT_T_LSB +: 8])
		axi_write(ADDR_CTRL, 32'h0000_5A01, r);
		axi_read(ADDR_CTRL, d, r);
		`CHK("ctrl readback", 32'h0000_5A01, d)
		$display("test dma_interrupt done");
		close_out();
	end
endmodule
